// >>> logic/psml_bus_if.sv
`timescale 1ns/1ps
interface psml_bus_if;
	// shared sideband wires, each driver except addrData and lockN given as value and enable
	logic [31:0] addrData;
	logic lockN;
	logic parityDev;
	logic parityDevOe;
	logic parityFar;
	logic parityFarOe;
	logic perrDevN;
	logic perrDevOe;
	logic perrFarN;
	logic perrFarOe;
	logic [3:0] reqDevN;
	logic [3:0] reqDevOe;
	logic [3:0] reqFarN;
	logic [3:0] reqFarOe;
	logic rstDevN;
	logic rstDevOe;
	logic rstFarN;
	logic rstFarOe;

	modport device (
		input addrData, lockN, parityFar, parityFarOe, perrFarN, perrFarOe,
		input reqFarN, reqFarOe, rstFarN, rstFarOe,
		output parityDev, parityDevOe, perrDevN, perrDevOe,
		output reqDevN, reqDevOe, rstDevN, rstDevOe
	);
	modport far (
		output addrData, lockN, parityFar, parityFarOe, perrFarN, perrFarOe,
		output reqFarN, reqFarOe, rstFarN, rstFarOe,
		input parityDev, parityDevOe, perrDevN, perrDevOe,
		input reqDevN, reqDevOe, rstDevN, rstDevOe
	);
endinterface : psml_bus_if

// >>> logic/psml_device.sv
// How it works
// R1: lock low marks exclusive access in progress
// R2: parity makes ones across bus even
// R3: master drives parity in address, write
// R4: target drives parity in read phases
// R5: parity error low two clocks after data; code drives it four clocks after, with two synchroniser stages added
// R6: host internal arbiter: four requests are inputs
// R7: host external: request0 driven, 3:1 high
// R8: satellite: request0 asserted when bus needed
// R9: satellite: request1 becomes configuration chip select
// R10: satellite: requests 3:2 driven high
// R11: host drives bus reset as output
// R12: satellite: bus reset input starts warm reset
// R13: mode straps latched at reset set directions
`timescale 1ns/1ps
module psml_device
	import psml_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// mode straps
	input wire logic strapHost,
	input wire logic strapExtArbiter,
	// user side
	input wire logic [1:0] phase,
	input wire logic parityDataValid,
	input wire logic needBus,
	input wire logic busResetReq,
	output logic [3:0] arbiterRequest,
	output logic exclusiveActive,
	output logic configSelect,
	output logic parityErrorSeen,
	output logic warmResetPulse,
	output logic hostMode,
	// pci side
	psml_bus_if.device bus
);
	logic [1:0] strapCnt_reg;
	logic [1:0] mode_reg;
	logic [1:0] lockSync_reg;
	logic [1:0] rstSync_reg;
	logic [1:0] idselSync_reg;
	logic [3:0] reqSync0_reg;
	logic [3:0] reqSync1_reg;
	logic [31:0] adSync0_reg;
	logic [31:0] adSync1_reg;
	logic [1:0] parSync_reg;
	logic [1:0] chkSync0_reg;
	logic [1:0] perrPipe_reg;
	logic rstSeen_reg;
	logic [4:0] rstCnt_reg;
	logic satellite;
	logic hostExt;

	assign satellite = (mode_reg == 2'(PSML_SATELLITE));
	assign hostExt = (mode_reg == 2'(PSML_HOST_EXT));

	// ----------------------------------------------------------------
	// mode capture
	// ----------------------------------------------------------------
	// straps caught one edge after release, never under reset itself
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			strapCnt_reg <= 2'h0;
			mode_reg <= 2'(PSML_HOST_INT);
		end
		else if (strapCnt_reg == 2'h0)
		begin
			strapCnt_reg <= 2'h1;
			if (!strapHost)
				mode_reg <= 2'(PSML_SATELLITE); // R13
			else if (strapExtArbiter)
				mode_reg <= 2'(PSML_HOST_EXT); // R13
			else
				mode_reg <= 2'(PSML_HOST_INT); // R13
		end
	end

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	// pins come from another agent: two flops before any logic but the driven parity, which reads addrData directly
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			lockSync_reg <= PSML_SYNC_RESET;
			rstSync_reg <= PSML_SYNC_RESET;
			idselSync_reg <= PSML_SYNC_RESET;
			reqSync0_reg <= PSML_REQ_IDLE;
			reqSync1_reg <= PSML_REQ_IDLE;
			adSync0_reg <= 32'h0000_0000;
			adSync1_reg <= 32'h0000_0000;
			parSync_reg <= 2'h0;
			chkSync0_reg <= 2'h0;
		end
		else
		begin
			lockSync_reg <= {lockSync_reg[0], bus.lockN};
			rstSync_reg <= {rstSync_reg[0], bus.rstFarN};
			idselSync_reg <= {idselSync_reg[0], bus.reqFarN[1]};
			reqSync0_reg <= bus.reqFarN;
			reqSync1_reg <= reqSync0_reg;
			adSync0_reg <= bus.addrData;
			adSync1_reg <= adSync0_reg;
			parSync_reg <= {parSync_reg[0], bus.parityFar};
			// two stages, so the strobe meets data and parity of its cycle
			chkSync0_reg <= {chkSync0_reg[0], parityDataValid};
		end
	end

	// ----------------------------------------------------------------
	// parity driving and checking
	// ----------------------------------------------------------------
	// we master address and write phases, target read phases
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.parityDev <= 1'b0;
			bus.parityDevOe <= 1'b0;
		end
		else
		begin
			bus.parityDev <= psml_even_parity(bus.addrData); // R2
			bus.parityDevOe <= (phase != 2'(PSML_IDLE)); // R3 R4
		end
	end

	// check aligns with the synchronised data; error two clocks later
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			perrPipe_reg <= 2'h0;
			bus.perrDevN <= 1'b1;
			bus.perrDevOe <= 1'b0;
			parityErrorSeen <= 1'b0;
		end
		else
		begin
			perrPipe_reg <= {perrPipe_reg[0], chkSync0_reg[1]
				& (psml_even_parity(adSync1_reg) != parSync_reg[1])}; // R2
			bus.perrDevN <= !perrPipe_reg[1]; // R5
			bus.perrDevOe <= perrPipe_reg[1]; // R5
			parityErrorSeen <= perrPipe_reg[1];
		end
	end

	// ----------------------------------------------------------------
	// request pins and lock
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.reqDevN <= PSML_REQ_IDLE;
			bus.reqDevOe <= 4'h0;
			arbiterRequest <= 4'h0;
			configSelect <= 1'b0;
			exclusiveActive <= 1'b0;
			hostMode <= 1'b1;
		end
		else
		begin
			hostMode <= !satellite;
			exclusiveActive <= !lockSync_reg[1]; // R1
			arbiterRequest <= (mode_reg == 2'(PSML_HOST_INT))
				? ~reqSync1_reg : 4'h0; // R6
			// the far end pulls the borrowed request pin low to select us
			configSelect <= satellite & !idselSync_reg[1]; // R9
			bus.reqDevN <= {3'h7, !(needBus & (hostExt | satellite))}; // R7 R8 R10
			// pins stay released until the straps have been taken
			if (strapCnt_reg == 2'h0)
				bus.reqDevOe <= 4'h0; // R13
			else if (hostExt)
				bus.reqDevOe <= 4'hF; // R7
			else if (satellite)
				bus.reqDevOe <= 4'hD; // R9 R10
			else
				bus.reqDevOe <= 4'h0; // R6
		end
	end

	// ----------------------------------------------------------------
	// bus reset
	// ----------------------------------------------------------------
	// in satellite mode a falling edge of the far reset starts one warm reset
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			rstSeen_reg <= 1'b1;
			rstCnt_reg <= PSML_CNT_RESET;
			bus.rstDevN <= 1'b0;
			bus.rstDevOe <= 1'b0;
			warmResetPulse <= 1'b0;
		end
		else
		begin
			rstSeen_reg <= rstSync_reg[1];
			warmResetPulse <= satellite & rstSeen_reg & !rstSync_reg[1]; // R12
			bus.rstDevOe <= (strapCnt_reg != 2'h0) & !satellite; // R11 R12 R13
			if (busResetReq)
				rstCnt_reg <= 5'(PSML_RST_CYCLES);
			else if (rstCnt_reg != 5'h00)
				rstCnt_reg <= rstCnt_reg - 5'h01;
			bus.rstDevN <= !(busResetReq | (rstCnt_reg != 5'h00)); // R11
		end
	end
endmodule : psml_device

// >>> logic/psml_far.sv
`timescale 1ns/1ps
module psml_far
	import psml_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// user side
	input wire logic [31:0] dataOut,
	input wire logic driveData,
	input wire logic driveParity,
	input wire logic badParity,
	input wire logic lockReq,
	input wire logic [3:0] requestN,
	input wire logic idselect,
	input wire logic resetReq,
	output logic perrSeen,
	// pci side
	psml_bus_if.far bus
);
	logic [1:0] perrSync_reg;

	// ----------------------------------------------------------------
	// pin ownership
	// ----------------------------------------------------------------
	// drive request and reset pins only where the device leaves them free, so none of them has two drivers
	assign bus.reqFarOe = ~bus.reqDevOe;
	assign bus.rstFarOe = !bus.rstDevOe;

	// ----------------------------------------------------------------
	// far agent drive
	// ----------------------------------------------------------------
	// bit 1 of request carries the chip select toward a satellite
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			bus.addrData <= 32'h0000_0000;
			bus.lockN <= 1'b1;
			bus.parityFar <= 1'b0;
			bus.parityFarOe <= 1'b0;
			bus.perrFarN <= 1'b1;
			bus.perrFarOe <= 1'b0;
			bus.reqFarN <= PSML_REQ_IDLE;
			bus.rstFarN <= 1'b1;
		end
		else
		begin
			bus.addrData <= driveData ? dataOut : bus.addrData;
			bus.lockN <= !lockReq; // R1
			bus.parityFar <= psml_even_parity(dataOut) ^ badParity; // R2
			bus.parityFarOe <= driveParity; // R3 R4
			bus.reqFarN <= {requestN[3:2], !idselect, requestN[0]};
			bus.rstFarN <= !resetReq;
		end
	end

	// device parity error seen through three flops
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			perrSync_reg <= 2'h0;
			perrSeen <= 1'b0;
		end
		else
		begin
			perrSync_reg <= {perrSync_reg[0],
				bus.perrDevOe & !bus.perrDevN};
			perrSeen <= perrSync_reg[1];
		end
	end
endmodule : psml_far

// >>> logic/psml_pkg.sv
package psml_pkg;
	// ----------------------------------------------------------------
	// bus geometry and timing
	// ----------------------------------------------------------------
	localparam int PSML_AD_W = 32;
	localparam int PSML_REQ_W = 4;
	localparam int PSML_PERR_DELAY = 2;
	localparam int PSML_RST_CYCLES = 16;
	localparam logic [3:0] PSML_REQ_IDLE = 4'hF;
	localparam logic [1:0] PSML_SYNC_RESET = 2'h3;
	localparam logic [4:0] PSML_CNT_RESET = 5'h00;

	// ----------------------------------------------------------------
	// modes and phases
	// ----------------------------------------------------------------
	typedef enum {PSML_HOST_INT, PSML_HOST_EXT, PSML_SATELLITE} psml_mode_t;
	typedef enum {PSML_IDLE, PSML_ADDR, PSML_WRITE, PSML_READ} psml_phase_t;

	// even parity: xor of all bits makes the total count of ones even
	function automatic logic psml_even_parity(input logic [31:0] value);
		psml_even_parity = ^value;
	endfunction : psml_even_parity
endpackage : psml_pkg

// >>> verification/psml_bus_sva.sv
`timescale 1ns/1ps
module psml_bus_sva
(
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// shared wires
	input wire logic [31:0] addrData,
	input wire logic parityDev,
	input wire logic parityDevOe,
	input wire logic parityFarOe,
	input wire logic perrDevN,
	input wire logic perrDevOe,
	input wire logic [3:0] reqDevN,
	input wire logic [3:0] reqDevOe,
	input wire logic rstDevN,
	input wire logic rstDevOe,
	input wire logic rstFarOe
);
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	// ----------------------------------------------------------------
	// wire rules
	// ----------------------------------------------------------------
	parity_even_a: assert property (parityDevOe && $past(parityDevOe)
		|-> parityDev == ^$past(addrData)) else $error("odd parity");
	parity_owner_a: assert property (!(parityDevOe && parityFarOe))
		else $error("two parity drivers");
	perr_level_a: assert property (perrDevOe |-> !perrDevN)
		else $error("error driven high");
	req_unused_a: assert property ((reqDevOe[3:1] & ~reqDevN[3:1]) == 3'h0)
		else $error("unused request low");
	req_group_a: assert property (reqDevOe[3] |-> reqDevOe[2] && reqDevOe[0])
		else $error("request group split");
	req_select_a: assert property (reqDevOe[1] |-> reqDevOe == 4'hF)
		else $error("select pin driven");
	rst_hold_a: assert property (rstDevOe && $fell(rstDevN)
		|-> (!rstDevN)[*8])
		else $error("bus reset too short");
	rst_length_a: assert property (rstDevOe && $rose(rstDevN)
		|-> !$past(rstDevN, 16))
		else $error("bus reset released early");
	rst_owner_a: assert property (!(rstDevOe && rstFarOe))
		else $error("two reset drivers");
endmodule : psml_bus_sva

// >>> verification/test_pci_sideband_mode_logic.sv
`timescale 1ns/1ps
module test_pci_sideband_mode_logic import psml_pkg::*; ;
	logic clock, resetn, strapHost, strapExt, pdv, needBus, busRst;
	logic [1:0] phase;
	logic [3:0] arbReq, requestN;
	logic excl, cfgSel, perrDev, warm, hostMode, perrFar;
	logic [31:0] dataOut;
	logic drvData, drvPar, badPar, lockReq, idsel, rstReq;
	int miscompares, samples_checked, cycles, n;
	psml_bus_if bus();
	psml_device psml_device_i (.clock(clock), .resetn(resetn),
		.strapHost(strapHost), .strapExtArbiter(strapExt), .phase(phase),
		.parityDataValid(pdv), .needBus(needBus), .busResetReq(busRst),
		.arbiterRequest(arbReq), .exclusiveActive(excl),
		.configSelect(cfgSel), .parityErrorSeen(perrDev),
		.warmResetPulse(warm), .hostMode(hostMode), .bus(bus));
	psml_far psml_far_i (.clock(clock), .resetn(resetn), .dataOut(dataOut),
		.driveData(drvData), .driveParity(drvPar), .badParity(badPar),
		.lockReq(lockReq), .requestN(requestN), .idselect(idsel),
		.resetReq(rstReq), .perrSeen(perrFar), .bus(bus));
	psml_bus_sva psml_bus_sva_i (.clock(clock), .resetn(resetn),
		.addrData(bus.addrData), .parityDev(bus.parityDev),
		.parityDevOe(bus.parityDevOe), .parityFarOe(bus.parityFarOe),
		.perrDevN(bus.perrDevN), .perrDevOe(bus.perrDevOe),
		.reqDevN(bus.reqDevN), .reqDevOe(bus.reqDevOe),
		.rstDevN(bus.rstDevN), .rstDevOe(bus.rstDevOe),
		.rstFarOe(bus.rstFarOe));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task chk(input logic ok, input string m);
		samples_checked++;
		if (ok !== 1'b1)
		begin
			miscompares++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(negedge clock);
	endtask : cyc
	// straps only count when sampled just after reset
	task boot(input logic h, input logic e);
		resetn = 1'b0;
		strapHost = h;
		strapExt = e;
		cyc(8);
		resetn = 1'b1;
		cyc(4);
	endtask : boot
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task t_arbiter;
		boot(1'b1, 1'b0);
		chk(hostMode === 1'b1, "host strap");
		requestN = 4'hA;
		lockReq = 1'b1;
		cyc(5);
		chk(arbReq === 4'h5, "arbiter view");
		chk(bus.reqDevOe === 4'h0, "request dir");
		chk(excl === 1'b1, "lock seen");
		requestN = 4'hF;
		lockReq = 1'b0;
		cyc(5);
		chk((arbReq === 4'h0) && (excl === 1'b0), "idle");
		$display("test arbiter done");
	endtask : t_arbiter
	task t_external;
		boot(1'b1, 1'b1);
		needBus = 1'b1;
		cyc(5);
		chk((bus.reqDevN === 4'hE) && (bus.reqDevOe === 4'hF), "ext");
		needBus = 1'b0;
		busRst = 1'b1;
		cyc(1);
		busRst = 1'b0;
		cyc(1);
		chk((bus.rstDevN === 1'b0) && (bus.rstDevOe === 1'b1), "rst");
		cyc(PSML_RST_CYCLES + 2);
		chk((bus.rstDevN === 1'b1) && (bus.reqDevN === 4'hF), "rel");
		$display("test external done");
	endtask : t_external
	task t_satellite;
		boot(1'b0, 1'b0);
		chk(hostMode === 1'b0, "sat strap");
		needBus = 1'b1;
		idsel = 1'b1;
		cyc(5);
		chk((bus.reqDevN[0] === 1'b0) && (cfgSel === 1'b1), "sat req");
		chk(bus.reqDevN[3:2] === 2'h3, "sat unused");
		idsel = 1'b0;
		needBus = 1'b0;
		rstReq = 1'b1;
		n = 0;
		while (n < 8 && warm !== 1'b1)
		begin
			cyc(1);
			n++;
		end
		chk((warm === 1'b1) && (cfgSel === 1'b0), "warm reset");
		chk(bus.rstDevOe === 1'b0, "reset dir");
		rstReq = 1'b0;
		$display("test satellite done");
	endtask : t_satellite
	// the far end sends 3 ones with flipped parity, then a clean word
	task t_parity;
		boot(1'b1, 1'b0);
		dataOut = 32'h00000007;
		drvData = 1'b1;
		phase = 2'h1;
		cyc(2);
		chk((bus.parityDev === 1'b1) && (bus.parityDevOe === 1'b1), "par");
		phase = 2'h0;
		drvPar = 1'b1;
		badPar = 1'b1;
		cyc(1);
		chk(bus.parityFar === 1'b0, "target parity");
		// flipped parity is on the pin only now: compare this cycle
		pdv = 1'b1;
		cyc(1);
		pdv = 1'b0;
		drvPar = 1'b0;
		n = 0;
		while (n < 8 && bus.perrDevN !== 1'b0)
		begin
			cyc(1);
			n++;
		end
		chk(bus.perrDevOe === 1'b1, "perr");
		// two synchroniser stages ahead of the two-clock delay
		chk(n == PSML_PERR_DELAY + 2, "perr delay");
		chk(perrDev === 1'b1, "perr flag");
		cyc(3);
		chk(perrFar === 1'b1, "perr at far end");
		badPar = 1'b0;
		cyc(1);
		pdv = 1'b1;
		cyc(1);
		pdv = 1'b0;
		cyc(4);
		chk((bus.perrDevOe === 1'b0) && (perrDev === 1'b0), "no perr");
		$display("test parity done");
	endtask : t_parity
	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// hang guard, far above the roughly one hundred ten cycles used
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			summarize();
		end
	end
	initial
	begin
		{resetn, strapHost, strapExt, pdv, needBus, busRst} = 6'h00;
		{drvData, drvPar, badPar, lockReq, idsel, rstReq} = 6'h00;
		phase = 2'h0;
		requestN = 4'hF;
		dataOut = 32'h00000000;
		t_arbiter();
		t_external();
		t_satellite();
		t_parity();
		summarize();
	end
endmodule : test_pci_sideband_mode_logic
